// ===== logic/sabu_pkg.sv
// constants for the sequencer alu and branch unit
package sabu_pkg;
    localparam int DW = 8;
    localparam int AW = 10;
    localparam int STACK_DEPTH = 4;
    localparam int SPW = 2;
    // register byte offsets
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_SRC  = 8'h04;
    localparam logic [7:0] REG_ACC  = 8'h08;
    localparam logic [7:0] REG_IDX  = 8'h0c;
    localparam logic [7:0] REG_RES  = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_PC   = 8'h18;
    // command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_RET_BIT = 4;
    localparam int CMD_DST_BIT = 5;
    localparam int CMD_IMM_LSB = 8;
    localparam int CMD_NA_LSB  = 16;
    localparam int CMD_SH_LSB  = 28;
    // status fields
    localparam int ST_ZERO  = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_DEPTH = 2;
    localparam int ST_TAKEN = 5;
    // opcodes
    localparam logic [3:0] OP_OR    = 4'h0;
    localparam logic [3:0] OP_AND   = 4'h1;
    localparam logic [3:0] OP_XOR   = 4'h2;
    localparam logic [3:0] OP_ADD   = 4'h3;
    localparam logic [3:0] OP_ADC   = 4'h4;
    localparam logic [3:0] OP_ROTATE_LEFT   = 4'h5;
    localparam logic [3:0] OP_JUMP_ALWAYS   = 4'h8;
    localparam logic [3:0] OP_JUMP_IF_CARRY = 4'h9;
    localparam logic [3:0] OP_JNC   = 4'ha;
    localparam logic [3:0] OP_CALL  = 4'hb;
    localparam logic [3:0] OP_XJNZ  = 4'hc;
    localparam logic [3:0] OP_AJNZ  = 4'hd;
    localparam logic [3:0] OP_XJZ   = 4'he;
    localparam logic [3:0] OP_AJZ   = 4'hf;
    // reset values and the nonseq transfer code
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [9:0]  RST_PC   = 10'h000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// ===== logic/sabu_core.sv
// sequencer alu and branch unit behind an ahb-lite register slave
// Notes on behaviour
// RULE1 - OR gives source OR operand into the destination
// RULE2 - AND gives source AND operand
// RULE3 - XOR gives source XOR operand
// RULE4 - logic and add ops use accumulator when immediate is zero, else immediate
// RULE5 - OR, AND, XOR and or-immediate keep carry unchanged
// RULE6 - ADD ignores the incoming carry
// RULE7 - add-with-carry adds the current carry in
// RULE8 - both adds set carry on overflow, clear it otherwise
// RULE9 - or-immediate always uses the immediate, even zero
// RULE10 - or-immediate writes its result into the index register
// RULE11 - rotate left by shift amount, carry updated
// RULE12 - every alu op updates zero from its result
// RULE13 - jump always loads the next-address field
// RULE14 - jump-if-zero branches when own result is zero, else sequential
// RULE15 - jump-if-not-zero branches when own result non-zero, else sequential
// RULE16 - zero branches test this command's result, not the old flag
// RULE17 - jump-if-carry branches when carry set, else sequential
// RULE18 - carry branches test carry left by an earlier command
// RULE19 - jump-if-not-carry branches when carry clear, else sequential
// RULE20 - call pushes current address plus one, then jumps
// RULE21 - return pops the stack top and continues there
// RULE22 - return bit set returns after the command's other work; a taken branch wins and nothing is popped
// RULE23 - opcode map 0..5 alu, 6..7 reserved, 8..15 branch forms
// RULE24 - data path and flags eight bits, carry out of the top bit
// RULE25 - with no branch and no return, program counter advances by one
//
// Local design decisions: the AHB-Lite register port and the address map.
module sabu_core
    import sabu_pkg::*;
(
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic          hready,
    input  wire logic [31:0]   hwdata,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // sequencer state
    output logic      [AW-1:0] prog_addr,
    output logic               zero_flag,
    output logic               carry_flag
);

    logic [31:0]   cmd_r;
    logic [DW-1:0] src_r;
    logic [DW-1:0] acc_r;
    logic [DW-1:0] idx_r;
    logic [DW-1:0] res_r;
    logic          zero_r;
    logic          carry_r;
    logic          taken_r;
    logic [AW-1:0] pc_r;
    logic [AW-1:0] stack_r [STACK_DEPTH];
    logic [SPW:0]  depth_r;
    logic          wr_pend_r;
    logic [7:0]    waddr_r;
    logic [31:0]   rdata_r;
    logic          hresetn_q;

    // bus decode
    wire        acc_req  = hsel && hready && htrans[1];
    wire        rd_req   = acc_req && !hwrite;
    wire [7:0]  a_off    = {haddr[7:2], 2'b00};
    wire        exec     = wr_pend_r && (waddr_r == REG_CMD);
    wire        wr_src   = wr_pend_r && (waddr_r == REG_SRC);
    wire        wr_acc   = wr_pend_r && (waddr_r == REG_ACC);
    wire        wr_idx   = wr_pend_r && (waddr_r == REG_IDX);
    wire        wr_pc    = wr_pend_r && (waddr_r == REG_PC);

    // command fields
    wire [3:0]    op     = hwdata[CMD_OP_LSB +: 4];
    wire          ret_b  = hwdata[CMD_RET_BIT];
    wire          dst_a  = hwdata[CMD_DST_BIT];
    wire [DW-1:0] imm    = hwdata[CMD_IMM_LSB +: DW];
    wire [AW-1:0] na     = hwdata[CMD_NA_LSB +: AW];
    wire [2:0]    sh     = hwdata[CMD_SH_LSB +: 3];

    // opcode decode
    wire f_or   = (op == OP_OR);
    wire f_and  = (op == OP_AND) || (op == OP_AJNZ) || (op == OP_AJZ);     // RULE23
    wire f_xor  = (op == OP_XOR) || (op == OP_XJNZ) || (op == OP_XJZ);     // RULE23
    wire f_add  = (op == OP_ADD);
    wire f_adc  = (op == OP_ADC);
    wire f_rot  = (op == OP_ROTATE_LEFT);
    wire f_orimm = (op[3:2] == 2'b10);                                     // RULE23
    wire fmt3   = op[3];
    wire valid  = !(op == 4'h6 || op == 4'h7);                             // RULE23

    // operand select and arithmetic
    wire [DW-1:0] opnd   = (imm == RST_BYTE) ? acc_r : imm;                // RULE4
    wire          cin    = f_adc ? carry_r : 1'b0;                         // RULE6 RULE7
    wire [DW:0]   sum    = {1'b0, src_r} + {1'b0, opnd} + {{DW{1'b0}}, cin}; // RULE24
    wire [2*DW-1:0] dbl  = {src_r, src_r} << sh;
    wire [DW-1:0] rot    = dbl[2*DW-1:DW];                                 // RULE11

    wire [DW-1:0] res    = f_and ? (src_r & opnd) :                        // RULE2
                           f_xor ? (src_r ^ opnd) :                        // RULE3
                           f_orimm ? (src_r | imm) :                       // RULE9
                           (f_add || f_adc) ? sum[DW-1:0] :
                           f_rot ? rot :
                           (src_r | opnd);                                 // RULE1
    wire          res_z  = (res == RST_BYTE);                              // RULE12 RULE16
    wire          carry_nxt = (f_add || f_adc) ? sum[DW] :                 // RULE8
                              f_rot ? rot[0] :                             // RULE11
                              carry_r;                                     // RULE5

    // branch decision
    wire j_now = (op == OP_JUMP_ALWAYS) || (op == OP_CALL);                // RULE13
    wire j_c   = (op == OP_JUMP_IF_CARRY) && carry_r;                      // RULE17 RULE18
    wire j_nc  = (op == OP_JNC) && !carry_r;                               // RULE19 RULE18
    wire j_z   = ((op == OP_XJZ) || (op == OP_AJZ)) && res_z;              // RULE14
    wire j_nz  = ((op == OP_XJNZ) || (op == OP_AJNZ)) && !res_z;           // RULE15
    wire taken = j_now || j_c || j_nc || j_z || j_nz;
    wire push  = (op == OP_CALL);
    wire pop   = ret_b && !taken && (depth_r != '0);
    wire [SPW-1:0] top    = SPW'(depth_r - 1'b1);
    wire [AW-1:0]  pc_inc = pc_r + 1'b1;
    wire [AW-1:0]  pc_nxt = taken ? na :                                   // RULE13
                            ret_b ? stack_r[top] :                         // RULE21 RULE22
                            pc_inc;                                        // RULE25

    // read mux
    wire [31:0] stat_w = {26'h0, taken_r, depth_r, carry_r, zero_r};
    wire [31:0] rd_mux = (a_off == REG_CMD)  ? cmd_r :
                         (a_off == REG_SRC)  ? {24'h0, src_r} :
                         (a_off == REG_ACC)  ? {24'h0, acc_r} :
                         (a_off == REG_IDX)  ? {24'h0, idx_r} :
                         (a_off == REG_RES)  ? {24'h0, res_r} :
                         (a_off == REG_STAT) ? stat_w :
                         (a_off == REG_PC)   ? {22'h0, pc_r} :
                         RST_WORD;

    // bus pipeline
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            waddr_r   <= RST_BYTE;
            rdata_r   <= RST_WORD;
        end
        else
        begin
            wr_pend_r <= acc_req && hwrite;
            waddr_r   <= a_off;
            if (rd_req)
                rdata_r <= rd_mux;
        end
    end

    // software loaded registers and results
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_r   <= RST_WORD;
            src_r   <= RST_BYTE;
            acc_r   <= RST_BYTE;
            idx_r   <= RST_BYTE;
            res_r   <= RST_BYTE;
            zero_r  <= 1'b0;
            carry_r <= 1'b0;
            taken_r <= 1'b0;
        end
        else
        begin
            if (wr_src)
                src_r <= hwdata[DW-1:0];
            if (wr_acc)
                acc_r <= hwdata[DW-1:0];
            else if (exec && valid && !fmt3 && dst_a)
                acc_r <= res;
            if (wr_idx)
                idx_r <= hwdata[DW-1:0];
            else if (exec && fmt3)
                idx_r <= res;                                              // RULE10
            if (exec)
            begin
                cmd_r   <= hwdata;
                taken_r <= taken;
            end
            if (exec && valid)
            begin
                res_r   <= res;
                zero_r  <= res_z;                                          // RULE12
                carry_r <= carry_nxt;                                      // RULE5 RULE8
            end
        end
    end

    // program counter and return stack
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc_r    <= RST_PC;
            depth_r <= '0;
        end
        else if (wr_pc)
            pc_r <= hwdata[AW-1:0];
        else if (exec)
        begin
            pc_r <= pc_nxt;
            if (push && depth_r != (SPW+1)'(STACK_DEPTH))
                depth_r <= depth_r + 1'b1;                                 // RULE20
            else if (pop)
                depth_r <= depth_r - 1'b1;                                 // RULE21
        end
    end

    generate
        for (genvar i = 0; i < STACK_DEPTH; i++)
        begin : g_stack
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    stack_r[i] <= RST_PC;
                else if (exec && push && depth_r == (SPW+1)'(i))
                    stack_r[i] <= pc_inc;                                  // RULE20
            end
        end
    endgenerate

    assign hrdata     = rdata_r;
    assign hreadyout  = hresetn_q;
    assign hresp      = 1'b0;
    assign prog_addr  = pc_r;
    assign zero_flag  = zero_r;
    assign carry_flag = carry_r;

    // ready flop: zero wait states once out of reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresetn_q <= 1'b0;
        else
            hresetn_q <= 1'b1;
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_exec(logic [3:0] o);
        exec && op == o && !wr_src && !wr_acc;
    endsequence

    a_or_operand: assert property (s_exec(OP_OR) |=> res_r == ($past(src_r) |  // RULE1 RULE4
        (($past(imm) == 8'h00) ? $past(acc_r) : $past(imm))))
        else $error("or result wrong");
    a_and_result: assert property (s_exec(OP_AND) |=> res_r == ($past(src_r) & // RULE2
        (($past(imm) == 8'h00) ? $past(acc_r) : $past(imm))))
        else $error("and result wrong");
    a_xor_result: assert property (s_exec(OP_XOR) |=> res_r == ($past(src_r) ^ // RULE3
        (($past(imm) == 8'h00) ? $past(acc_r) : $past(imm))))
        else $error("xor result wrong");
    a_logic_carry_hold: assert property (exec && (f_or || f_and || f_xor || f_orimm) // RULE5
        |=> $stable(carry_r))
        else $error("logic op altered carry");
    a_add_carry_out: assert property (s_exec(OP_ADD) |=> carry_r == // RULE6 RULE8
        ((9'($past(src_r)) + 9'($past(opnd))) > 9'h0ff))
        else $error("add carry wrong");
    a_adc_carry_in: assert property (s_exec(OP_ADC) |=> res_r == // RULE7
        8'($past(src_r) + $past(opnd) + 8'($past(carry_r))))
        else $error("adc sum wrong");
    a_orimm_index: assert property (exec && f_orimm && !wr_idx |=> // RULE9 RULE10
        idx_r == ($past(src_r) | $past(imm)))
        else $error("or-immediate index wrong");
    a_zero_flag: assert property (exec && valid |=> zero_r == (res_r == 8'h00)) // RULE12
        else $error("zero flag mismatch");
    a_jump_target: assert property (exec && !wr_pc && op == OP_JUMP_ALWAYS |=> // RULE13
        pc_r == $past(na))
        else $error("jump target wrong");
    a_zero_branch: assert property (exec && (op == OP_XJZ || op == OP_AJZ) && !ret_b // RULE14 RULE16
        |=> pc_r == (zero_r ? $past(na) : $past(pc_r) + 10'h001))
        else $error("zero branch wrong");
    a_carry_branch: assert property (exec && op == OP_JUMP_IF_CARRY && !ret_b |=> // RULE17 RULE18
        pc_r == ($past(carry_r) ? $past(na) : $past(pc_r) + 10'h001))
        else $error("carry branch wrong");

    // stack push and pop
    sequence s_call_depth(logic [SPW:0] d);
        exec && push && depth_r == d;
    endsequence

    sequence s_ret_depth(logic [SPW:0] d);
        exec && !taken && ret_b && depth_r == d;
    endsequence

    a_call_push: assert property (s_call_depth(3'h0) |=> stack_r[0] == $past(pc_r) + 10'h001 && // RULE20
        depth_r == 3'h1 && pc_r == $past(na))
        else $error("call push wrong");

    a_call_nested: assert property (s_call_depth(3'h1) |=> stack_r[1] == $past(pc_r) + 10'h001 && // RULE20
        depth_r == 3'h2)
        else $error("nested call push wrong");

    a_return_pop: assert property (s_ret_depth(3'h1) |=> pc_r == $past(stack_r[0]) && // RULE21 RULE22
        depth_r == 3'h0)
        else $error("return pop wrong");

    a_return_nested: assert property (s_ret_depth(3'h2) |=> pc_r == $past(stack_r[1]) && // RULE21 RULE22
        depth_r == 3'h1)
        else $error("nested return pop wrong");

    a_depth_bound: assert property (depth_r <= (SPW+1)'(STACK_DEPTH)) // RULE20
        else $error("stack depth out of range");

    a_seq_advance: assert property (exec && !taken && !ret_b |=> // RULE25
        pc_r == $past(pc_r) + 10'h001)
        else $error("sequential advance wrong");

    a_pc_idle: assert property (!exec && !wr_pc |=> $stable(pc_r))
        else $error("program counter moved while idle");

    // branch outcomes
    a_not_zero_branch: assert property (exec && (op == OP_XJNZ || op == OP_AJNZ) && !ret_b // RULE15 RULE16
        |=> pc_r == (!zero_r ? $past(na) : $past(pc_r) + 10'h001))
        else $error("not-zero branch wrong");

    a_not_carry_branch: assert property (exec && op == OP_JNC && !ret_b |=> // RULE19 RULE18
        pc_r == (!$past(carry_r) ? $past(na) : $past(pc_r) + 10'h001))
        else $error("not-carry branch wrong");

    a_branch_carry_hold: assert property (exec && (op == OP_JUMP_IF_CARRY || op == OP_JNC) |=> // RULE18
        $stable(carry_r))
        else $error("carry branch altered carry");

    a_taken_flag: assert property (exec && j_now |=> taken_r) // RULE13
        else $error("unconditional branch not flagged");

    // arithmetic and rotate
    a_add_sum: assert property (s_exec(OP_ADD) |=> res_r == 8'($past(src_r) + $past(opnd))) // RULE6
        else $error("add sum wrong");

    a_adc_carry_out: assert property (s_exec(OP_ADC) |=> carry_r == // RULE7 RULE8
        ((9'($past(src_r)) + 9'($past(opnd)) + 9'($past(carry_r))) > 9'h0ff))
        else $error("adc carry wrong");

    a_rotate_result: assert property (s_exec(OP_ROTATE_LEFT) |=> res_r == // RULE11
        (($past(src_r) << $past(sh)) | ($past(src_r) >> (4'h8 - 4'($past(sh))))))
        else $error("rotate result wrong");

    a_rotate_carry: assert property (s_exec(OP_ROTATE_LEFT) |=> carry_r == res_r[0]) // RULE11
        else $error("rotate carry wrong");

    // destinations and reserved codes
    a_and_branch_index: assert property (exec && (op == OP_AJZ || op == OP_AJNZ) |=> // RULE2 RULE10
        idx_r == ($past(src_r) & (($past(imm) == 8'h00) ? $past(acc_r) : $past(imm))))
        else $error("and branch index wrong");

    a_xor_branch_index: assert property (exec && (op == OP_XJZ || op == OP_XJNZ) |=> // RULE3 RULE10
        idx_r == ($past(src_r) ^ (($past(imm) == 8'h00) ? $past(acc_r) : $past(imm))))
        else $error("xor branch index wrong");

    a_acc_kept: assert property (exec && (fmt3 || !dst_a) |=> $stable(acc_r)) // RULE10
        else $error("accumulator altered without destination");

    a_reserved_hold: assert property (exec && !valid |=> $stable(res_r) && $stable(zero_r) && // RULE23
        $stable(carry_r) && $stable(acc_r))
        else $error("reserved opcode changed state");

    a_src_kept: assert property (exec |=> $stable(src_r))
        else $error("source register altered");

    a_pc_load: assert property (wr_pc |=> pc_r == $past(hwdata[AW-1:0]))
        else $error("program counter load wrong");

    a_read_pc: assert property (rd_req && a_off == REG_PC |=> hrdata == {22'h0, $past(pc_r)})
        else $error("program counter read wrong");

endmodule // sabu_core

// ===== tb/sabu_bench.sv
// self-checking bench for the sequencer alu and branch unit
module sabu_bench
    import sabu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic          hclk;
    logic          hresetn = 1'b0;
    logic          hsel    = 1'b1;
    logic [31:0]   haddr   = 32'h0000_0000;
    logic [1:0]    htrans  = 2'h0;
    logic          hwrite  = 1'b0;
    logic [2:0]    hsize   = 3'h2;
    logic [31:0]   hwdata  = 32'h0000_0000;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic [AW-1:0] prog_addr;
    logic          zero_flag;
    logic          carry_flag;
    int            miscompares = 0;
    int            checks      = 0;
    // reference model state
    logic [7:0]    ms = 8'h00, ma = 8'h00, mi = 8'h00, mr = 8'h00;
    logic          mz = 1'b0, mc = 1'b0;
    logic [9:0]    mp = 10'h000;
    logic [9:0]    stk[$];

    sabu_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .prog_addr(prog_addr), .zero_flag(zero_flag),
        .carry_flag(carry_flag));

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic give_verdict;
        if (miscompares == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // one single transfer: address phase, then data phase, each held until hready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge hclk);
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(posedge hclk);
                n++;
            end
            while (hreadyout !== 1'b1 && n < 40);
            if (n >= 40)
            begin
                miscompares++;
                give_verdict();
            end
            htrans <= 2'h0;
            hwdata <= d;
        end
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0000_0000, r);
        chk(r, e);
    endtask

    task automatic ld(input logic [7:0] s, input logic [7:0] a);
        ms = s;
        ma = a;
        wr(REG_SRC, {24'h00_0000, s});
        wr(REG_ACC, {24'h00_0000, a});
    endtask

    // issue one command, advance the model, compare result, pc, acc, index, status and pins
    task automatic run(input logic [3:0] op, input logic [7:0] im, input logic [9:0] na,
                       input logic [2:0] sh, input logic rt, input logic ds);
        logic [7:0]  o;
        logic [8:0]  s;
        logic [15:0] q;
        logic        tk;
        logic [9:0]  nx;
        logic [31:0] r;
        o  = (im == 8'h00) ? ma : im;
        s  = {1'b0, ms} + {1'b0, o};
        q  = {ms, ms} << sh;
        nx = mp + 10'h001;
        case (op)
            OP_OR:                   mr = ms | o;
            OP_AND, OP_AJNZ, OP_AJZ: mr = ms & o;
            OP_XOR, OP_XJNZ, OP_XJZ: mr = ms ^ o;
            OP_ADD, OP_ADC:          {mc, mr} = s + ((op == OP_ADC) ? {8'h00, mc} : 9'h000);
            OP_ROTATE_LEFT:          {mc, mr} = {q[8], q[15:8]};
            4'h6, 4'h7:              ;
            default:                 mr = ms | im;
        endcase
        if (op != 4'h6 && op != 4'h7)
            mz = (mr == 8'h00);
        case (op)
            OP_JUMP_ALWAYS, OP_CALL: tk = 1'b1;
            OP_JUMP_IF_CARRY: tk = mc;
            OP_JNC:           tk = !mc;
            OP_XJNZ, OP_AJNZ: tk = !mz;
            OP_XJZ, OP_AJZ:   tk = mz;
            default:          tk = 1'b0;
        endcase
        if (op >= OP_JUMP_ALWAYS)
            mi = mr;
        else if (ds && op < 4'h6)
            ma = mr;
        if (op == OP_CALL && stk.size() < STACK_DEPTH)
            stk.push_back(nx);
        if (tk)
            nx = na;
        else if (rt)
            nx = stk.pop_back();
        mp = nx;
        wr(REG_CMD, {1'b0, sh, 2'b00, na, im, 2'b00, ds, rt, op});
        rdc(REG_RES, {24'h00_0000, mr});
        rdc(REG_PC, {22'h00_0000, mp});
        rdc(REG_ACC, {24'h00_0000, ma});
        rdc(REG_IDX, {24'h00_0000, mi});
        bus(REG_STAT, 1'b0, 32'h0000_0000, r);
        chk(r & 32'h0000_003f, {26'h0, tk, 3'(stk.size()), mc, mz});
        chk({19'h0, hresp, carry_flag, zero_flag, prog_addr}, {19'h0, 1'b0, mc, mz, mp});
    endtask

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(REG_PC, 32'h0000_0000);
        rdc(REG_STAT, 32'h0000_0000);
        ld(8'h5a, 8'h0f);
        run(OP_OR, 8'h00, 10'h000, 3'h0, 1'b0, 1'b1);
        run(OP_OR, 8'h81, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_AND, 8'h00, 10'h000, 3'h0, 1'b0, 1'b1);
        run(OP_AND, 8'h0f, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_XOR, 8'h00, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_XOR, 8'hff, 10'h000, 3'h0, 1'b0, 1'b0);
        ld(8'hf0, 8'h10);
        run(OP_ADD, 8'h20, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_OR, 8'h01, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_ADC, 8'h0f, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_ADD, 8'h01, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_ADC, 8'h00, 10'h000, 3'h0, 1'b0, 1'b1);
        ld(8'h96, 8'h0f);
        for (int k = 0; k < 8; k++)
            run(OP_ROTATE_LEFT, 8'h00, 10'h000, 3'(k), 1'b0, 1'b0);
        run(OP_JUMP_ALWAYS, 8'h00, 10'h2a5, 3'h0, 1'b0, 1'b0);
        run(OP_ADD, 8'hff, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_JUMP_IF_CARRY, 8'h01, 10'h155, 3'h0, 1'b0, 1'b0);
        run(OP_JNC, 8'h00, 10'h0aa, 3'h0, 1'b0, 1'b0);
        run(OP_ADD, 8'h01, 10'h000, 3'h0, 1'b0, 1'b0);
        run(OP_JUMP_IF_CARRY, 8'h00, 10'h155, 3'h0, 1'b0, 1'b0);
        run(OP_JNC, 8'h02, 10'h0aa, 3'h0, 1'b0, 1'b0);
        run(OP_CALL, 8'h00, 10'h300, 3'h0, 1'b0, 1'b0);
        run(OP_CALL, 8'h00, 10'h320, 3'h0, 1'b0, 1'b0);
        run(OP_OR, 8'h01, 10'h000, 3'h0, 1'b1, 1'b0);
        run(OP_XOR, 8'h00, 10'h000, 3'h0, 1'b1, 1'b0);
        ld(8'h3c, 8'h3c);
        run(OP_XJZ, 8'h00, 10'h111, 3'h0, 1'b0, 1'b0);
        run(OP_AJZ, 8'h0f, 10'h122, 3'h0, 1'b0, 1'b0);
        run(OP_AJNZ, 8'hc3, 10'h133, 3'h0, 1'b0, 1'b0);
        run(OP_XJNZ, 8'h01, 10'h144, 3'h0, 1'b0, 1'b0);
        run(OP_AJZ, 8'hc3, 10'h155, 3'h0, 1'b0, 1'b0);
        mp = 10'h3fd;
        wr(REG_PC, 32'h0000_03fd);
        run(OP_OR, 8'h02, 10'h000, 3'h0, 1'b0, 1'b0);
        rdc(8'h40, 32'h0000_0000);
        wr(REG_RES, 32'h0000_00ff);
        rdc(REG_RES, {24'h00_0000, mr});
        run(4'h6, 8'h00, 10'h000, 3'h0, 1'b0, 1'b0);
        run(4'h7, 8'h00, 10'h000, 3'h0, 1'b0, 1'b0);
        give_verdict();
    end
endmodule // sabu_bench
